//--- rtl/fsp_pkg.sv
package fsp_pkg;
  // Register byte addresses on the Avalon-MM slave
  localparam logic [7:0] OFF_FLASH_CMD = 8'h00;
  localparam logic [7:0] OFF_FLASH_STATUS = 8'h04;
  localparam logic [7:0] OFF_CMD_PROTECT = 8'h08;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h0c;
  localparam logic [7:0] OFF_PROTECT_BYTE = 8'h10;
  localparam logic [7:0] OFF_PROTECT_MASK = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;

  // Flash location that holds the protect byte
  localparam logic [15:0] PROTECT_BYTE_ADDR = 16'h0081;
  // Protect select field sits in bits 6..2 of the protect byte
  localparam int SEL_LSB = 2;
  localparam int SEL_MSB = 6;

  // Unlock key for the command-protect register
  localparam logic [7:0] UNLOCK_KEY = 8'ha5;

  // Flash status register bit positions
  localparam int STAT_SEQ_ERR = 0;
  localparam int STAT_WP_ERR = 2;
  localparam logic [7:0] STAT_WR_MASK = 8'h05;

  // Protect select codes
  localparam logic [4:0] SEL_ALL_OPEN = 5'h1f;
  localparam logic [4:0] SEL16_FIRST = 5'h08;
  localparam logic [4:0] SEL8_FIRST = 5'h0c;
  localparam logic [4:0] SEL_LAST = 5'h0f;
  localparam logic [4:0] TOP16_FIRST = 5'h0f;
  localparam logic [4:0] TOP8_FIRST = 5'h07;

  // Interrupt event bit positions
  localparam int IRQ_SEQ_ERR = 0;
  localparam int IRQ_WP_ERR = 1;
  localparam int IRQ_MODE_SET = 2;
  localparam int IRQ_BITS = 3;

  // Reset values
  localparam logic [7:0] RST_FLASH_CMD = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_PROTECT_BYTE = 8'hff;
  localparam logic [2:0] RST_IRQ_ENABLE = 3'h0;

  // Guarded sequence states, one-hot
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_ARMED = 4'h2,
    SEQ_FIRST = 4'h4,
    SEQ_SECOND = 4'h8
  } fsp_seq_type;
endpackage

//--- rtl/fsp_protect_decode.sv
// Turns the protect select field into a per-block protect mask
module fsp_protect_decode (
  input wire logic [4:0] sel_i,
  input wire logic variant16_i,
  output logic [15:0] mask_o,
  output logic prohibited_o
);
  logic [4:0] top; // Highest protected block
  logic code_ok; // Code listed for this variant
  logic any_prot; // At least one block protected

  // Highest protected block for a listed code, two blocks per code step
  function automatic logic [4:0] top_block(input logic [4:0] sel, input logic [4:0] first,
                                           input logic [4:0] first_top);
    logic [4:0] step;
    step = sel - first;
    top_block = first_top - {step[3:0], 1'b0};
  endfunction

  // Code lookup per variant
  always_comb begin
    if (variant16_i) begin
      code_ok = (sel_i >= fsp_pkg::SEL16_FIRST) && (sel_i <= fsp_pkg::SEL_LAST);
      top = top_block(sel_i, fsp_pkg::SEL16_FIRST, fsp_pkg::TOP16_FIRST);
    end else begin
      code_ok = (sel_i >= fsp_pkg::SEL8_FIRST) && (sel_i <= fsp_pkg::SEL_LAST);
      top = top_block(sel_i, fsp_pkg::SEL8_FIRST, fsp_pkg::TOP8_FIRST);
    end
  end

  // Prohibited codes protect everything: fail safe rather than open
  assign prohibited_o = !code_ok && (sel_i != fsp_pkg::SEL_ALL_OPEN);
  assign any_prot = code_ok || prohibited_o;

  // One comparator per block
  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : g_blk
      assign mask_o[b] = prohibited_o || (any_prot && (5'(b) <= top));
    end
  endgenerate
endmodule

//--- rtl/fsp_entry_ctrl.sv
module fsp_entry_ctrl (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [7:0] prot_byte_i,
  input wire logic variant16_i,
  input wire logic op_req_i,
  input wire logic [3:0] op_block_i,
  output logic op_grant_o,
  output logic op_denied_o,
  output logic self_prog_o,
  output logic [15:0] block_protect_o,
  output logic flash_cmd_o,
  output logic irq_o
);
  // Bus handshake state
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic wr_acc; // Write taken this cycle
  logic [7:0] wd; // Low byte of write data

  // Sequencer state
  fsp_pkg::fsp_seq_type state, next_state;
  logic [7:0] first_val, next_first_val; // Value of the first mode write
  logic mode, next_mode; // Self-programming mode
  logic seq_err_set; // Sequence failed this cycle
  logic mode_set_evt; // Third write applied this cycle

  // Registers
  logic [7:0] flash_cmd, next_flash_cmd;
  logic [7:0] status, next_status;
  logic [7:0] prot_byte, next_prot_byte;
  logic [15:0] prot_mask, next_prot_mask;
  logic prohibited, next_prohibited;
  logic variant_q, next_variant_q; // Strap caught after reset
  logic strap_done, next_strap_done;
  logic strap_meta, strap_sync; // Variant pin through two flops

  // Interrupt and operation path
  logic [fsp_pkg::IRQ_BITS-1:0] irq_stat, next_irq_stat;
  logic [fsp_pkg::IRQ_BITS-1:0] irq_en, next_irq_en;
  logic [fsp_pkg::IRQ_BITS-1:0] irq_evt;
  logic next_irq;
  logic next_grant, next_denied;
  logic [15:0] dec_mask;
  logic dec_prohibited;

  // Address match used by every register branch
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // Field decode for the protect byte
  fsp_protect_decode u_decode (
    .sel_i(prot_byte[fsp_pkg::SEL_MSB:fsp_pkg::SEL_LSB]),
    .variant16_i(variant_q),
    .mask_o(dec_mask),
    .prohibited_o(dec_prohibited)
  );

  assign wd = avs_writedata_i[7:0];
  // Only the low lane carries register bits; a write without it is a no-op
  assign wr_acc = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

  // Bus: one wait cycle, then a single ready cycle with read data
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata_o;
    if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      next_waitrequest = 1'b0;
      next_readdata = 32'h0000_0000; // Unmapped reads return zero
      if (hit(avs_address_i, fsp_pkg::OFF_FLASH_CMD)) begin
        next_readdata[7:0] = flash_cmd;
      end else if (hit(avs_address_i, fsp_pkg::OFF_FLASH_STATUS)) begin
        next_readdata[7:0] = status;
      end else if (hit(avs_address_i, fsp_pkg::OFF_MODE_CTRL)) begin
        next_readdata[0] = mode;
      end else if (hit(avs_address_i, fsp_pkg::OFF_PROTECT_BYTE)) begin
        next_readdata[8:0] = {prohibited, prot_byte};
      end else if (hit(avs_address_i, fsp_pkg::OFF_PROTECT_MASK)) begin
        next_readdata[15:0] = prot_mask;
      end else if (hit(avs_address_i, fsp_pkg::OFF_IRQ_STATUS)) begin
        next_readdata[fsp_pkg::IRQ_BITS-1:0] = irq_stat;
      end else if (hit(avs_address_i, fsp_pkg::OFF_IRQ_ENABLE)) begin
        next_readdata[fsp_pkg::IRQ_BITS-1:0] = irq_en;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o <= next_readdata;
    end
  end

  // Guarded unlock sequence; reads never break it, writes elsewhere do
  always_comb begin
    next_state = state;
    next_first_val = first_val;
    next_mode = mode;
    seq_err_set = 1'b0;
    mode_set_evt = 1'b0;
    if (wr_acc) begin
      if (hit(avs_address_i, fsp_pkg::OFF_CMD_PROTECT)) begin
        // A fresh key restarts; interrupting a half-done sequence fails it
        seq_err_set = (state == fsp_pkg::SEQ_FIRST) || (state == fsp_pkg::SEQ_SECOND);
        next_state = (wd == fsp_pkg::UNLOCK_KEY) ? fsp_pkg::SEQ_ARMED : fsp_pkg::SEQ_IDLE;
      end else if (hit(avs_address_i, fsp_pkg::OFF_MODE_CTRL)) begin
        case (state)
          fsp_pkg::SEQ_ARMED: begin
            next_first_val = wd; // Held, not applied
            next_state = fsp_pkg::SEQ_FIRST;
          end
          fsp_pkg::SEQ_FIRST: begin
            if (wd == ~first_val) begin
              next_state = fsp_pkg::SEQ_SECOND; // Inverse, not applied
            end else begin
              seq_err_set = 1'b1;
              next_state = fsp_pkg::SEQ_IDLE;
            end
          end
          fsp_pkg::SEQ_SECOND: begin
            next_state = fsp_pkg::SEQ_IDLE;
            if (wd == first_val) begin
              next_mode = wd[0]; // Third write takes effect
              mode_set_evt = 1'b1;
            end else begin
              seq_err_set = 1'b1;
            end
          end
          default: begin
            seq_err_set = 1'b1; // Unguarded mode write refused
            next_state = fsp_pkg::SEQ_IDLE;
          end
        endcase
      end else if (state != fsp_pkg::SEQ_IDLE) begin
        seq_err_set = 1'b1; // Foreign write breaks the order
        next_state = fsp_pkg::SEQ_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= fsp_pkg::SEQ_IDLE;
      first_val <= 8'h00;
      mode <= 1'b0;
    end else begin
      state <= next_state;
      first_val <= next_first_val;
      mode <= next_mode;
    end
  end

  // Strap pin is not timed to this clock; runs through reset so it is settled
  always_ff @(posedge clk_sys_i) begin
    strap_meta <= variant16_i;
    strap_sync <= strap_meta;
  end

  // Plain registers, flash status and protect decode
  always_comb begin
    next_flash_cmd = flash_cmd;
    next_status = status;
    next_prot_byte = prot_byte_i; // Flash array drives the byte at 0081H
    next_prot_mask = dec_mask;
    next_prohibited = dec_prohibited;
    next_strap_done = 1'b1;
    next_variant_q = strap_done ? variant_q : strap_sync;
    if (wr_acc && hit(avs_address_i, fsp_pkg::OFF_FLASH_CMD)) begin
      next_flash_cmd = wd;
    end
    if (wr_acc && hit(avs_address_i, fsp_pkg::OFF_FLASH_STATUS)) begin
      next_status = wd & fsp_pkg::STAT_WR_MASK;
    end
    // Hardware sets win over a clearing write in the same cycle
    if (seq_err_set) begin
      next_status[fsp_pkg::STAT_SEQ_ERR] = 1'b1;
    end
    if (next_denied) begin
      next_status[fsp_pkg::STAT_WP_ERR] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      flash_cmd <= fsp_pkg::RST_FLASH_CMD;
      status <= fsp_pkg::RST_STATUS;
      prot_byte <= fsp_pkg::RST_PROTECT_BYTE;
      prot_mask <= 16'h0000;
      prohibited <= 1'b0;
      variant_q <= 1'b0;
      strap_done <= 1'b0;
    end else begin
      flash_cmd <= next_flash_cmd;
      status <= next_status;
      prot_byte <= next_prot_byte;
      prot_mask <= next_prot_mask;
      prohibited <= next_prohibited;
      variant_q <= next_variant_q;
      strap_done <= next_strap_done;
    end
  end

  // Write/erase gating and interrupt logic
  always_comb begin
    // Outside self-programming the mask does not restrict anything
    next_denied = op_req_i && mode && prot_mask[op_block_i];
    next_grant = op_req_i && !next_denied;
    irq_evt = '0;
    irq_evt[fsp_pkg::IRQ_SEQ_ERR] = seq_err_set;
    irq_evt[fsp_pkg::IRQ_WP_ERR] = next_denied;
    irq_evt[fsp_pkg::IRQ_MODE_SET] = mode_set_evt;
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    if (wr_acc && hit(avs_address_i, fsp_pkg::OFF_IRQ_ENABLE)) begin
      next_irq_en = wd[fsp_pkg::IRQ_BITS-1:0];
    end
    if (wr_acc && hit(avs_address_i, fsp_pkg::OFF_IRQ_CLEAR)) begin
      next_irq_stat = irq_stat & ~wd[fsp_pkg::IRQ_BITS-1:0];
    end
    next_irq_stat = next_irq_stat | irq_evt; // Set beats clear
    next_irq = |(next_irq_stat & next_irq_en);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_stat <= '0;
      irq_en <= fsp_pkg::RST_IRQ_ENABLE;
      irq_o <= 1'b0;
      op_grant_o <= 1'b0;
      op_denied_o <= 1'b0;
      self_prog_o <= 1'b0;
      block_protect_o <= 16'h0000;
      flash_cmd_o <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      irq_o <= next_irq;
      op_grant_o <= next_grant;
      op_denied_o <= next_denied;
      self_prog_o <= next_mode;
      block_protect_o <= next_prot_mask;
      flash_cmd_o <= |next_flash_cmd;
    end
  end

  // Checks on the decode, sequencer and gating
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_mode_wr;
    wr_acc && hit(avs_address_i, fsp_pkg::OFF_MODE_CTRL);
  endsequence

  sequence s_other_wr;
    wr_acc && !hit(avs_address_i, fsp_pkg::OFF_MODE_CTRL)
      && !hit(avs_address_i, fsp_pkg::OFF_CMD_PROTECT);
  endsequence

  chk_mask_eight: assert property (
    strap_done && !variant_q && prot_byte[6:2] == 5'h0d |=> prot_mask == 16'h003f)
    else $error("eight-block code 01101 mask wrong");

  chk_mask_sixteen: assert property (
    strap_done && variant_q && prot_byte[6:2] == 5'h0a |=> prot_mask == 16'h0fff)
    else $error("sixteen-block code 01010 mask wrong");

  chk_all_open: assert property (
    strap_done && prot_byte == 8'hff |=> prot_mask == 16'h0000 && !prohibited)
    else $error("all-ones code did not open every block");

  chk_third_write: assert property (
    state == fsp_pkg::SEQ_SECOND and s_mode_wr and wd == first_val
      |=> mode == $past(wd[0]) ##1 self_prog_o == $past(mode))
    else $error("third mode write not applied");

  chk_early_ignored: assert property (
    (state == fsp_pkg::SEQ_ARMED or state == fsp_pkg::SEQ_FIRST) and s_mode_wr
      |=> $stable(mode))
    else $error("early mode write changed mode");

  chk_unguarded_err: assert property (
    state == fsp_pkg::SEQ_IDLE and s_mode_wr |=> status[0] && $stable(mode))
    else $error("unguarded mode write not flagged");

  chk_break_abort: assert property (
    state != fsp_pkg::SEQ_IDLE and s_other_wr
      |=> state == fsp_pkg::SEQ_IDLE && status[0] && $stable(mode))
    else $error("broken sequence not aborted");

  chk_normal_open: assert property (
    op_req_i && !mode |=> op_grant_o && !op_denied_o)
    else $error("operation restricted outside self-programming");

  chk_wp_flag: assert property (
    op_req_i && mode && prot_mask[op_block_i] |=> op_denied_o && !op_grant_o && status[2])
    else $error("protected block operation not refused");
endmodule

//--- test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus side of the block
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [7:0] prot = 8'hff;
  logic v16 = 1'b0;
  logic op_req = 1'b0;
  logic [3:0] op_blk = 4'h0;
  // Observed outputs
  logic [31:0] rdata;
  logic waitreq, grant, denied, sp, fcmd, irq;
  logic [15:0] bprot;
  // Bookkeeping
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] q;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  fsp_entry_ctrl u_fsp_entry_ctrl (
    .clk_sys_i(clk),
    .sys_rst_i(rst),
    .avs_address_i(addr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdata),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq),
    .prot_byte_i(prot),
    .variant16_i(v16),
    .op_req_i(op_req),
    .op_block_i(op_blk),
    .op_grant_o(grant),
    .op_denied_o(denied),
    .self_prog_o(sp),
    .block_protect_o(bprot),
    .flash_cmd_o(fcmd),
    .irq_o(irq)
  );

  // Compare one value, report at once
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Single verdict point
  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low at a
  // rising edge, read data taken at that edge; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (waitreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask

  // Guarded write sequence with free mode values; ops never target its code
  task automatic seq(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    wrr(8'h08, fsp_pkg::UNLOCK_KEY);
    wrr(8'h0c, x);
    wrr(8'h0c, y);
    wrr(8'h0c, z);
  endtask

  // One-cycle write/erase request, verdict one edge later
  task automatic op(input logic [3:0] b, input logic g, input logic d);
    @(posedge clk);
    op_req <= 1'b1;
    op_blk <= b;
    @(posedge clk);
    op_req <= 1'b0;
    @(negedge clk);
    chk({30'h0, grant, denied}, {30'h0, g, d});
  endtask

  // Reset with the variant strap held
  task automatic do_reset(input logic v);
    @(posedge clk);
    rst <= 1'b1;
    v16 <= v;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Expected protect mask: blocks zero up to a top that falls by two per code
  function automatic logic [15:0] exp_mask(input logic v, input logic [4:0] c);
    int top;
    logic [16:0] m;
    if (c == fsp_pkg::SEL_ALL_OPEN) return 16'h0000;
    top = v ? 15 - 2 * (int'(c) - 8) : 7 - 2 * (int'(c) - 12);
    m = (17'h00001 << (top + 1)) - 17'h00001;
    return m[15:0];
  endfunction

  // Load a protect code and check both views of the mask
  task automatic prot_case(input logic v, input logic [4:0] c);
    @(posedge clk);
    prot <= {1'b1, c, 2'b11};
    repeat (4) @(posedge clk);
    rdc(8'h14, {16'h0, exp_mask(v, c)});
    chk({16'h0, bprot}, {16'h0, exp_mask(v, c)});
  endtask

  // Watchdog: the tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    do_reset(1'b0);
    // Reset values and an unmapped place
    rdc(8'h0c, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h20, 32'h0);
    rdc(8'h10, 32'h0ff);
    rdc(8'h30, 32'h0);
    chk({31'h0, sp}, 32'h0);
    // Eight-block codes plus the open code
    for (int c = 12; c <= 15; c++) prot_case(1'b0, c[4:0]);
    prot_case(1'b0, 5'h1f);
    // Unlisted code raises the prohibited flag
    @(posedge clk);
    prot <= 8'h83;
    repeat (4) @(posedge clk);
    rdc(8'h10, 32'h183);
    prot_case(1'b0, 5'h0e);
    // Normal mode never restricts
    op(4'h0, 1'b1, 1'b0);
    // Command register, a masked byte lane is ignored
    wrr(8'h00, 8'h03);
    be <= 4'he;
    wrr(8'h00, 8'h00);
    be <= 4'hf;
    rdc(8'h00, 32'h3);
    chk({31'h0, fcmd}, 32'h1);
    wrr(8'h00, 8'h00);
    rdc(8'h00, 32'h0);
    // Mode write without key, wrong inverse, foreign write mid-way
    wrr(8'h0c, 8'h01);
    rdc(8'h04, 32'h1);
    rdc(8'h0c, 32'h0);
    wrr(8'h04, 8'h00);
    rdc(8'h04, 32'h0);
    seq(8'h01, 8'hff, 8'h01);
    rdc(8'h04, 32'h1);
    rdc(8'h0c, 32'h0);
    wrr(8'h04, 8'h00);
    wrr(8'h08, fsp_pkg::UNLOCK_KEY);
    wrr(8'h0c, 8'h01);
    wrr(8'h00, 8'h00);
    rdc(8'h04, 32'h1);
    wrr(8'h04, 8'h00);
    wrr(8'h20, 8'h00);
    // Valid entry; reads in between do not break it
    wrr(8'h08, fsp_pkg::UNLOCK_KEY);
    wrr(8'h0c, 8'h01);
    rdc(8'h0c, 32'h0);
    wrr(8'h0c, 8'hfe);
    rdc(8'h0c, 32'h0);
    wrr(8'h0c, 8'h01);
    repeat (2) @(posedge clk);
    rdc(8'h0c, 32'h1);
    chk({31'h0, sp}, 32'h1);
    rdc(8'h04, 32'h0);
    // Earlier sequence errors stay sticky beside the mode-set event
    rdc(8'h18, 32'h5);
    // Gate in self-programming mode, with the error interrupt
    wrr(8'h1c, 8'h07);
    wrr(8'h20, 8'h02);
    op(4'h2, 1'b0, 1'b1);
    op(4'h4, 1'b1, 1'b0);
    rdc(8'h04, 32'h4);
    rdc(8'h18, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wrr(8'h20, 8'h00);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wrr(8'h20, 8'h02);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wrr(8'h1c, 8'h02);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h18, 32'h0);
    // Back to normal mode, protection lifted
    seq(8'h00, 8'hff, 8'h00);
    rdc(8'h0c, 32'h0);
    op(4'h0, 1'b1, 1'b0);
    // Sixteen-block codes
    do_reset(1'b1);
    for (int c = 8; c <= 15; c++) prot_case(1'b1, c[4:0]);
    prot_case(1'b1, 5'h1f);
    tally_and_finish();
  end
endmodule
